/* File: verilog/sswm_top.sv */
// Serial switch matrix control: frame-gated shift register, latch and chain output
//
// Operation
// RULE1: Each latched bit drives one switch enable; one closes, zero opens.
// RULE2: Unchanged on bits keep their enable steady across an update, no glitch.
// RULE3: Power-up clears shift register and switches until first valid write latches.
// RULE4: Eight-bit shift register always keeps the last eight bits shifted in.
// RULE5: Shifting enabled only while frame-sync is low; falling edge starts frame.
// RULE6: During a frame, data shifts in on each serial clock falling edge.
// RULE7: Chain output changes on rising edges, lagging input by eight bits.
// RULE8: Frame-sync rising edge latches register to all enables, stops shifting.
// RULE9: With frame-sync high, data and clock activity changes nothing.
// RULE10: Host supplies eight bits, each stable at the serial clock falling edge.
// RULE11: Host lowers frame-sync before clocking, raises it after eight bits.
// RULE12: Host sends the control word most significant bit first.
// RULE13: Active-low reset pin clears register and forces all enables off.
// RULE14: Chain output is open drain: pulls low for zero, releases for one.
// RULE15: Logic works up to the maximum serial rate; host stays below it. Here 50 MHz sampling limits the serial clock far below the 30 MHz maximum.
// RULE16: Bit seven drives switch eight, bit zero switch one; nibbles form banks.
`timescale 1ns/1ps
module sswm_top
  import sswm_pkg::*;
#(
  parameter int WIDTH = SSWM_WIDTH
)
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic reset_n_in,
  input wire logic host_transmit_frame_n_in,
  input wire logic serial_clk_in,
  input wire logic serial_data_in,
  output logic [WIDTH-1:0] switch_source_terminal_en_out,
  output logic [SSWM_BANK_WIDTH-1:0] bank_a_en_out,
  output logic [SSWM_BANK_WIDTH-1:0] bank_b_en_out,
  output logic chain_data_out,
  output logic chain_data_oe_out,
  output logic frame_active_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SSWM_IDLE = 2'b01,
    SSWM_SHIFT = 2'b10
  } sswm_mode_t;

  typedef struct packed {
    sswm_mode_t mode;
    logic [WIDTH-1:0] shift;
    logic [WIDTH-1:0] latched;
    logic chain;
    logic rst_meta;
    logic rst_sync;
  } sswm_state_t;

  sswm_state_t state_ff;
  sswm_state_t nxt_state;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Both resets share one picture of a cleared block
  function automatic sswm_state_t clear_core();
    sswm_state_t res;
    res.mode = SSWM_IDLE;
    res.shift = WIDTH'(SSWM_RESET_VALUE);
    res.latched = WIDTH'(SSWM_RESET_VALUE);
    res.chain = 1'b1;
    res.rst_meta = 1'b0;
    res.rst_sync = 1'b0;
    return res;
  endfunction : clear_core

  // Only bits that differ are rewritten, so a switch held on sees no toggle
  function automatic logic [WIDTH-1:0] merge_update
  (
    input logic [WIDTH-1:0] old_bits,
    input logic [WIDTH-1:0] new_bits
  );
    logic [WIDTH-1:0] res;
    res = old_bits;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (old_bits[i] != new_bits[i])
      begin
        res[i] = new_bits[i];
      end
    end
    return res;
  endfunction : merge_update

  function automatic logic [SSWM_BANK_WIDTH-1:0] bank_of(input logic [WIDTH-1:0] bits, input int lsb);
    return bits[lsb +: SSWM_BANK_WIDTH];
  endfunction : bank_of

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic frame_level;
  logic frame_rise;
  logic frame_fall;
  logic sclk_rise;
  logic sclk_fall;
  logic data_level;

  // Idle frame-sync is high, so reset to high avoids a false start
  sswm_sync #(.RESET_LEVEL(1'b1)) u_frame_sync
  (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .async_in(host_transmit_frame_n_in),
    .level_out(frame_level),
    .rise_out(frame_rise),
    .fall_out(frame_fall)
  );

  sswm_sync #(.RESET_LEVEL(1'b0)) u_sclk_sync // RULE15
  (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .async_in(serial_clk_in),
    .level_out(),
    .rise_out(sclk_rise),
    .fall_out(sclk_fall)
  );

  // Same latency as the clock path keeps data aligned to its sampling edge
  sswm_sync #(.RESET_LEVEL(1'b0)) u_data_sync
  (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .async_in(serial_data_in),
    .level_out(data_level),
    .rise_out(),
    .fall_out()
  );

  logic frame_start;
  logic frame_end;

  // Level terms recover an edge that fell while the block was held clear
  assign frame_start = frame_fall | ~frame_level;
  assign frame_end = frame_rise | frame_level;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    nxt_state.rst_meta = reset_n_in;
    nxt_state.rst_sync = state_ff.rst_meta;
    if (!state_ff.rst_sync)
    begin
      nxt_state = clear_core(); // RULE13
      nxt_state.rst_meta = reset_n_in;
      nxt_state.rst_sync = state_ff.rst_meta;
    end
    else
    begin
      case (state_ff.mode)
        SSWM_IDLE:
        begin
          // Serial clock and data ignored here
          if (frame_start) // RULE5 RULE9
          begin
            nxt_state.mode = SSWM_SHIFT;
          end
        end
        SSWM_SHIFT:
        begin
          if (frame_end)
          begin
            // All enables updated in one edge; held bits see no change
            nxt_state.latched = merge_update(state_ff.latched, state_ff.shift); // RULE8 RULE2
            nxt_state.mode = SSWM_IDLE; // RULE8
          end
          else
          begin
            if (sclk_fall)
            begin
              nxt_state.shift = {state_ff.shift[WIDTH-2:0], data_level}; // RULE6 RULE4 RULE12
            end
            if (sclk_rise)
            begin
              nxt_state.chain = state_ff.shift[WIDTH-1]; // RULE7
            end
          end
        end
        default:
        begin
          nxt_state.mode = SSWM_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      state_ff <= clear_core(); // RULE3
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Sampling at 50 MHz limits the serial clock far below the pin maximum
  assign switch_source_terminal_en_out = state_ff.latched; // RULE1 RULE16
  assign bank_a_en_out = bank_of(state_ff.latched, SSWM_BANK_A_LSB); // RULE16
  assign bank_b_en_out = bank_of(state_ff.latched, SSWM_BANK_B_LSB); // RULE16
  assign chain_data_out = 1'b0;
  assign chain_data_oe_out = ~state_ff.chain; // RULE14
  assign frame_active_out = (state_ff.mode == SSWM_SHIFT);

endmodule : sswm_top

/* File: inc/sswm_pkg.sv */
// Package of constants and types for the serial switch matrix control block
package sswm_pkg;
  localparam int SSWM_WIDTH = 8;
  localparam logic [7:0] SSWM_RESET_VALUE = 8'h00;
  localparam int SSWM_SYNC_STAGES = 2;
  localparam int SSWM_CLK_PERIOD_NS = 20;
  localparam int SSWM_LINK_MAX_MHZ = 30;
  localparam int SSWM_BANK_A_LSB = 0;
  localparam int SSWM_BANK_B_LSB = 4;
  localparam int SSWM_BANK_WIDTH = 4;
endpackage : sswm_pkg

/* File: verilog/sswm_sync.sv */
// Two-flop synchroniser with edge detection on the second stage output
`timescale 1ns/1ps
module sswm_sync
  import sswm_pkg::*;
#(
  parameter logic RESET_LEVEL = 1'b0
)
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic async_in,
  output logic level_out,
  output logic rise_out,
  output logic fall_out
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } sswm_sync_state_t;

  sswm_sync_state_t state_ff;
  sswm_sync_state_t nxt_state;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_state.meta = async_in;
    nxt_state.sync = state_ff.meta;
    nxt_state.prev = state_ff.sync;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      state_ff <= {RESET_LEVEL, RESET_LEVEL, RESET_LEVEL};
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // Edges come from stages two and three only, never the metastable stage
  assign level_out = state_ff.sync;
  assign rise_out = state_ff.sync & ~state_ff.prev;
  assign fall_out = ~state_ff.sync & state_ff.prev;

endmodule : sswm_sync

/* File: testbench/sswm_host_model.sv */
// Host serial port model: frame, link clock and data
`timescale 1ns/1ps
module sswm_host_model (
  input wire logic clk_sys_in,
  input wire logic chain_oe_in,
  output logic frame_n_out,
  output logic sclk_out,
  output logic data_out,
  output logic [7:0] chain_out
);
  initial
  begin
    frame_n_out = 1'b1;
    sclk_out = 1'b0;
    data_out = 1'b0;
  end
  // Half of a 160 ns link period, far under the top rate
  task automatic half();
    repeat (4) @(negedge clk_sys_in);
  endtask : half
  task automatic send(input int n, input logic [15:0] w);
    frame_n_out = 1'b0;
    half();
    for (int i = n - 1; i >= 0; i--)
    begin
      data_out = w[i];
      sclk_out = 1'b1;
      half();
      sclk_out = 1'b0;
      half();
      // Pull-up reads one while the chain pin is released
      chain_out = {chain_out[6:0], !chain_oe_in};
    end
    frame_n_out = 1'b1;
    data_out = !data_out;
    half();
    half();
  endtask : send
  task automatic noise();
    repeat (8)
    begin
      sclk_out = !sclk_out;
      data_out = !data_out;
      half();
    end
  endtask : noise
endmodule : sswm_host_model

/* File: testbench/sswm_top_assertions.sv */
// Port checker for the switch matrix control block
`timescale 1ns/1ps
module sswm_top_assertions
  import sswm_pkg::*;
#(
  parameter int WIDTH = SSWM_WIDTH
)
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic reset_n_in,
  input wire logic host_transmit_frame_n_in,
  input wire logic serial_clk_in,
  input wire logic serial_data_in,
  input wire logic [WIDTH-1:0] switch_source_terminal_en_out,
  input wire logic [SSWM_BANK_WIDTH-1:0] bank_a_en_out,
  input wire logic [SSWM_BANK_WIDTH-1:0] bank_b_en_out,
  input wire logic chain_data_out,
  input wire logic chain_data_oe_out,
  input wire logic frame_active_out
);
  wire [WIDTH-1:0] en = switch_source_terminal_en_out;
  default clocking @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);
  sequence idle_s;
    (host_transmit_frame_n_in && reset_n_in)[*8];
  endsequence
  sequence shift_s;
    (!host_transmit_frame_n_in && reset_n_in)[*6];
  endsequence
  a_bank_map: assert property ({bank_b_en_out, bank_a_en_out} == en) else $error("bank map");
  a_chain_low: assert property (chain_data_out == 1'b0) else $error("chain value");
  a_idle_hold: assert property (idle_s |-> $stable(en) && !frame_active_out) else $error("idle");
  a_frame_mode: assert property (shift_s |-> frame_active_out) else $error("mode");
  a_shift_hold: assert property (frame_active_out && reset_n_in |-> $stable(en)) else $error("hold");
  a_update_time: assert property ($changed(en) |-> $past(host_transmit_frame_n_in, 2)
    || !$past(reset_n_in, 3)) else $error("update");
  a_pin_clear: assert property (!reset_n_in[*5] |-> en == 0 && !chain_data_oe_out) else $error("pin");
  a_power_clear: assert property ($fell(rst_in) |-> (en == 0)[*3]) else $error("power");
endmodule : sswm_top_assertions
bind sswm_top sswm_top_assertions #(.WIDTH(WIDTH)) sswm_top_assertions_i (.*);

/* File: testbench/sswm_top_tb.sv */
// Self-checking bench for the switch matrix control block
`timescale 1ns/1ps
module sswm_top_tb
  import sswm_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rn = 1'b1;
  logic fs, sck, sd, oe, act;
  logic [7:0] en, shreg, exp_en, rx;
  logic [3:0] ba, bb;
  logic [7:0] q[$];
  int n_fail = 0;
  int checks_done = 0;
  int seed = 15222;
  always #10 clk = !clk;
  sswm_top sswm_top_i (.clk_sys_in(clk), .rst_in(rst), .reset_n_in(rn), .host_transmit_frame_n_in(fs),
    .serial_clk_in(sck), .serial_data_in(sd), .switch_source_terminal_en_out(en), .bank_a_en_out(ba),
    .bank_b_en_out(bb), .chain_data_out(), .chain_data_oe_out(oe), .frame_active_out(act));
  sswm_host_model sswm_host_model_i (.clk_sys_in(clk), .chain_oe_in(oe), .frame_n_out(fs),
    .sclk_out(sck), .data_out(sd), .chain_out(rx));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic stop_test();
    if (n_fail == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test
  task automatic frame(input int n, input logic [15:0] d);
    logic [7:0] prev;
    prev = shreg;
    for (int i = n - 1; i >= 0; i--)
      shreg = {shreg[6:0], d[i]};
    if (shreg != exp_en)
      q.push_back(shreg);
    exp_en = shreg;
    sswm_host_model_i.send(n, d);
    chk("active", 8'h00, {7'h00, act});
    chk("banks", exp_en, {bb, ba});
    if (n == 8)
      chk("chain", prev, rx);
  endtask : frame
  // Enables change only on a latch or a pin reset, so every change consumes one note
  always @(en)
    if (!rst)
    begin
      if (q.size() == 0)
        chk("idle", exp_en, en);
      else
        chk("enables", q.pop_front(), en);
    end
  initial
  begin
    shreg = 8'h00;
    exp_en = 8'h00;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (6) @(negedge clk);
    chk("power", 8'h00, en);
    frame(8, 16'h00A5);
    frame(8, 16'h00A4);
    frame(12, 16'h0F3C);
    frame(3, 16'h0005);
    repeat (6)
      frame(8, 16'($random(seed)));
    sswm_host_model_i.noise();
    rn = 1'b0;
    if (exp_en != 8'h00)
      q.push_back(8'h00);
    shreg = 8'h00;
    exp_en = 8'h00;
    repeat (8) @(negedge clk);
    rn = 1'b1;
    repeat (6) @(negedge clk);
    frame(8, 16'h00FF);
    for (int k = 0; k < 50 && q.size() > 0; k++)
      @(negedge clk);
    chk("pending", 8'h00, 8'(q.size()));
    stop_test();
  end
endmodule : sswm_top_tb
